//--- core/wic_cfg.svh
/*
  Constants of the write-only two-wire control block: device address, select codes,
  field positions, reset values and bus timing.
  Assumes it is included by bare name from every file that names a constant.
*/
`ifndef WIC_CFG_SVH
`define WIC_CFG_SVH

// ************************************************************
// Bus framing
// ************************************************************
`define WIC_DEV_ADDR 7'h60
`define WIC_BIT_LAST 4'h7
`define WIC_BIT_ACK 4'h8
`define WIC_BIT_FIRST 4'h1
`define WIC_CNT_ZERO 4'h0
`define WIC_SDA_LOW 1'b0
`define WIC_SCL_MAX_KHZ 400
`define WIC_CLK_KHZ 10000
`define WIC_SCL_MIN_CYC ((`WIC_CLK_KHZ + `WIC_SCL_MAX_KHZ - 1) / `WIC_SCL_MAX_KHZ)

// ************************************************************
// Command byte layout
// ************************************************************
`define WIC_F_SEL 7:5
`define WIC_F_SUB 4:2
`define WIC_B_MARK 4
`define WIC_SEL_SHUT 3'h0
`define WIC_SEL_MODE 3'h1
`define WIC_SEL_LIMIT 3'h2
`define WIC_SEL_CLIP 3'h3
`define WIC_SEL_GAIN 3'h4
`define WIC_SEL_VOL 3'h5
`define WIC_SEL_GATE 3'h6
`define WIC_SEL_EXT 3'h7
`define WIC_SUB_RAIL 3'h2
`define WIC_SUB_MISC 3'h4

// ************************************************************
// Payload fields
// ************************************************************
`define WIC_B_ENABLE 0
`define WIC_B_RAIL_DIS 1
`define WIC_B_RPHONE_DIS 2
`define WIC_B_UNUSED_DIS 3
`define WIC_F_MODE 3:0
`define WIC_B_BYPASS 4
`define WIC_F_LEVEL 2:0
`define WIC_F_TIME2 4:3
`define WIC_B_SPK_GAIN 3
`define WIC_F_PHONE_GAIN 2:0
`define WIC_F_VOL 4:0
`define WIC_F_GATE_LEVEL 3:2
`define WIC_F_LOW2 1:0
`define WIC_B_SPREAD 1
`define WIC_B_FAST_ON 0
`define WIC_LIM_MIN 3'h1
`define WIC_LIM_MAX 3'h6
`define WIC_CLIP_OFF 3'h0
`define WIC_CLIP_LOW 3'h3
`define WIC_CLIP_HIGH 3'h5
`define WIC_RST_BIT 1'b0
`define WIC_RST_BYTE 8'h00

`endif

//--- core/wic_pkg.sv
/*
  Types of the write-only two-wire control block.
  Assumes wic_cfg.svh holds every number.
*/
package wic_pkg;

  typedef enum logic [3:0] {
    WIC_ST_IDLE = 4'b0001,
    WIC_ST_ADDR = 4'b0010,
    WIC_ST_DATA = 4'b0100,
    WIC_ST_WAIT = 4'b1000
  } wic_state_e;

  typedef enum logic [3:0] {
    WIC_T_NONE, WIC_T_SHUT, WIC_T_MODE, WIC_T_LIMIT, WIC_T_CLIP,
    WIC_T_GAIN, WIC_T_VOL, WIC_T_GATE, WIC_T_RAIL, WIC_T_MISC
  } wic_tgt_e;

endpackage

//--- core/wic_link_rx.sv
/*
  Link-side receiver: frames, address match, acknowledge and byte hand-off.
  Assumes SCL comes only from the master and runs only within frames.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wic_cfg.svh"

module wic_link_rx (
  // Link pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oe_o,
  // Reset
  input wire logic srst_i,
  // Received byte
  output logic [7:0] byte_o,
  output logic wr_tgl_o
);

  logic start_ff;
  logic stop_ff;
  logic start_ack_ff;
  logic flag_clr;
  logic ack_req_ff;
  logic addr_hit;
  logic [3:0] cnt_ff;
  logic [7:0] shift_ff;
  wic_pkg::wic_state_e state_ff;

  // ************************************************************
  // Start and stop
  // ************************************************************
  // The clear is a gate output; it only pulses long after SDA settles.
  assign flag_clr = srst_i | start_ack_ff;

  always_ff @(negedge sda_i or posedge flag_clr) begin
    if (flag_clr) begin
      start_ff <= `WIC_RST_BIT;
    end else if (scl_i) begin
      start_ff <= 1'b1;
    end
  end

  always_ff @(posedge sda_i or posedge flag_clr) begin
    if (flag_clr) begin
      stop_ff <= `WIC_RST_BIT;
    end else if (scl_i) begin
      stop_ff <= 1'b1;
    end
  end

  always_ff @(posedge scl_i or posedge srst_i) begin
    if (srst_i) begin
      start_ack_ff <= `WIC_RST_BIT;
    end else begin
      start_ack_ff <= start_ff;
    end
  end

  // ************************************************************
  // Bit framing
  // ************************************************************
  assign addr_hit = (shift_ff[6:0] == `WIC_DEV_ADDR) && !sda_i;

  always_ff @(posedge scl_i or posedge srst_i) begin
    if (srst_i) begin
      state_ff <= wic_pkg::WIC_ST_IDLE;
      cnt_ff <= `WIC_CNT_ZERO;
      shift_ff <= `WIC_RST_BYTE;
    end else if (start_ff) begin
      state_ff <= wic_pkg::WIC_ST_ADDR;
      cnt_ff <= `WIC_BIT_FIRST;
      shift_ff <= {7'h00, sda_i};
    end else begin
      case (state_ff)
        wic_pkg::WIC_ST_ADDR, wic_pkg::WIC_ST_DATA: begin
          if (cnt_ff == `WIC_BIT_ACK) begin
            cnt_ff <= `WIC_CNT_ZERO;
            state_ff <= (state_ff == wic_pkg::WIC_ST_ADDR) ? wic_pkg::WIC_ST_DATA : wic_pkg::WIC_ST_WAIT;
          end else begin
            shift_ff <= {shift_ff[6:0], sda_i};
            cnt_ff <= cnt_ff + 4'h1;
            if ((cnt_ff == `WIC_BIT_LAST) && (state_ff == wic_pkg::WIC_ST_ADDR) && !addr_hit) begin
              state_ff <= wic_pkg::WIC_ST_IDLE;
            end
          end
        end
        wic_pkg::WIC_ST_WAIT: begin
          if (stop_ff) begin
            state_ff <= wic_pkg::WIC_ST_IDLE;
          end
        end
        wic_pkg::WIC_ST_IDLE: begin
          state_ff <= wic_pkg::WIC_ST_IDLE;
        end
        default: begin
          state_ff <= wic_pkg::WIC_ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Acknowledge and hand-off
  // ************************************************************
  always_ff @(posedge scl_i or posedge srst_i) begin
    if (srst_i) begin
      ack_req_ff <= `WIC_RST_BIT;
      byte_o <= `WIC_RST_BYTE;
      wr_tgl_o <= `WIC_RST_BIT;
    end else if (start_ff) begin
      ack_req_ff <= `WIC_RST_BIT;
    end else if (cnt_ff == `WIC_BIT_LAST) begin
      if ((state_ff == wic_pkg::WIC_ST_ADDR) && addr_hit) begin
        ack_req_ff <= 1'b1;
      end
      if (state_ff == wic_pkg::WIC_ST_DATA) begin
        ack_req_ff <= 1'b1;
        byte_o <= {shift_ff[6:0], sda_i};
        wr_tgl_o <= ~wr_tgl_o;
      end
    end else if (cnt_ff == `WIC_BIT_ACK) begin
      ack_req_ff <= `WIC_RST_BIT;
    end
  end

  // SDA changes only while SCL is low, so our own pull never looks like a start or stop.
  always_ff @(negedge scl_i or posedge srst_i) begin
    if (srst_i) begin
      sda_oe_o <= `WIC_RST_BIT;
    end else begin
      sda_oe_o <= ack_req_ff;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge scl_i); endclocking
  default disable iff (srst_i);

  read_nack_a: assert property (state_ff == wic_pkg::WIC_ST_ADDR && cnt_ff == `WIC_BIT_LAST && sda_i && !start_ff |=> !ack_req_ff && state_ff == wic_pkg::WIC_ST_IDLE) else $error("read address acked");
  start_frame_a: assert property (start_ff |=> state_ff == wic_pkg::WIC_ST_ADDR && cnt_ff == `WIC_BIT_FIRST) else $error("start not framed");
  addr_ack_a: assert property (state_ff == wic_pkg::WIC_ST_ADDR && cnt_ff == `WIC_BIT_LAST && addr_hit && !start_ff |=> ack_req_ff) else $error("address not acked");
  oe_tracks_a: assert property (sda_oe_o == ack_req_ff) else $error("ack drive out of phase");
  byte_len_a: assert property (cnt_ff <= `WIC_BIT_ACK) else $error("byte longer than nine clocks");
  data_ack_a: assert property (state_ff == wic_pkg::WIC_ST_DATA && cnt_ff == `WIC_BIT_LAST && !start_ff |=> ack_req_ff && wr_tgl_o != $past(wr_tgl_o)) else $error("data byte not acked");
  wait_ignore_a: assert property (state_ff == wic_pkg::WIC_ST_WAIT && !start_ff |=> state_ff != wic_pkg::WIC_ST_ADDR && state_ff != wic_pkg::WIC_ST_DATA) else $error("traffic taken after byte");
  addr_cov_c: cover property (state_ff == wic_pkg::WIC_ST_ADDR ##1 state_ff == wic_pkg::WIC_ST_DATA);

endmodule

`default_nettype wire

//--- core/wic_ctrl_top.sv
/*
  Write-only two-wire control slave: link receiver plus the control register file.
  Assumes SCL/SDA pins from a bus master and a 10 MHz system clock clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "wic_cfg.svh"

module wic_ctrl_top (
  // System
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // Two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Power-down controls
  output logic device_enable_o,
  output logic rail_switch_disable_o,
  output logic right_phone_disable_o,
  output logic unused_amp_disable_o,
  // Routing
  output logic [3:0] mixer_mode_o,
  output logic receiver_bypass_o,
  output logic class_d_enable_o,
  // Limiter and anti-clip
  output logic [2:0] limit_level_o,
  output logic limit_active_o,
  output logic [1:0] attack_time_o,
  output logic [2:0] clip_code_o,
  output logic [1:0] release_time_o,
  output logic anti_clip_on_o,
  output logic clip_ctrl_on_o,
  // Gain and volume
  output logic speaker_gain_sel_o,
  output logic [2:0] phone_gain_sel_o,
  output logic [4:0] volume_step_o,
  // Noise gate, class G and misc
  output logic [1:0] gate_level_o,
  output logic [1:0] gate_time_o,
  output logic [1:0] rail_trip_o,
  output logic spread_enable_o,
  output logic fast_turn_on_o
);

  logic [7:0] link_byte;
  logic link_tgl;
  logic [2:0] tgl_sync_ff;
  logic wr_evt;
  logic wr_ff;
  logic [7:0] byte_q_ff;
  logic en_ff;
  logic rail_dis_ff;
  logic rphone_dis_ff;
  logic unused_dis_ff;
  wic_pkg::wic_tgt_e tgt;

  // ************************************************************
  // Target decode
  // ************************************************************
  function automatic wic_pkg::wic_tgt_e wic_decode(input logic [7:0] b);
    wic_pkg::wic_tgt_e t;
    t = wic_pkg::WIC_T_NONE;
    case (b[`WIC_F_SEL])
      `WIC_SEL_SHUT: t = b[`WIC_B_MARK] ? wic_pkg::WIC_T_SHUT : wic_pkg::WIC_T_NONE;
      `WIC_SEL_MODE: t = wic_pkg::WIC_T_MODE;
      `WIC_SEL_LIMIT: t = wic_pkg::WIC_T_LIMIT;
      `WIC_SEL_CLIP: t = wic_pkg::WIC_T_CLIP;
      `WIC_SEL_GAIN: t = wic_pkg::WIC_T_GAIN;
      `WIC_SEL_VOL: t = wic_pkg::WIC_T_VOL;
      `WIC_SEL_GATE: t = wic_pkg::WIC_T_GATE;
      `WIC_SEL_EXT: begin
        if (b[`WIC_F_SUB] == `WIC_SUB_RAIL) begin
          t = wic_pkg::WIC_T_RAIL;
        end else if (b[`WIC_F_SUB] == `WIC_SUB_MISC) begin
          t = wic_pkg::WIC_T_MISC;
        end
      end
      default: t = wic_pkg::WIC_T_NONE;
    endcase
    return t;
  endfunction

  assign tgt = wic_decode(byte_q_ff);

  // ************************************************************
  // Link side
  // ************************************************************
  // SCL is only ever an input here; the slave never stretches the clock.
  wic_link_rx u_link (
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_oe_o(sda_oe_o),
    .srst_i(srst_i),
    .byte_o(link_byte),
    .wr_tgl_o(link_tgl)
  );

  // Open drain: the data output is always low, only the enable moves.
  always_ff @(posedge clk_i) begin
    sda_o <= `WIC_SDA_LOW;
  end

  // ************************************************************
  // Crossing into the system clock
  // ************************************************************
  // The byte is held by the link until the next frame, far longer than the toggle takes.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tgl_sync_ff <= 3'h0;
    end else if (ce_i) begin
      tgl_sync_ff <= {tgl_sync_ff[1:0], link_tgl};
    end
  end

  assign wr_evt = tgl_sync_ff[2] ^ tgl_sync_ff[1];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_ff <= `WIC_RST_BIT;
      byte_q_ff <= `WIC_RST_BYTE;
    end else if (ce_i) begin
      wr_ff <= wr_evt;
      if (wr_evt) begin
        byte_q_ff <= link_byte;
      end
    end
  end

  // ************************************************************
  // Register file
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      en_ff <= `WIC_RST_BIT;
      rail_dis_ff <= `WIC_RST_BIT;
      rphone_dis_ff <= `WIC_RST_BIT;
      unused_dis_ff <= `WIC_RST_BIT;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_SHUT) begin
      en_ff <= byte_q_ff[`WIC_B_ENABLE];
      rail_dis_ff <= byte_q_ff[`WIC_B_RAIL_DIS];
      rphone_dis_ff <= byte_q_ff[`WIC_B_RPHONE_DIS];
      unused_dis_ff <= byte_q_ff[`WIC_B_UNUSED_DIS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mixer_mode_o <= 4'h0;
      receiver_bypass_o <= `WIC_RST_BIT;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_MODE) begin
      mixer_mode_o <= byte_q_ff[`WIC_F_MODE];
      receiver_bypass_o <= byte_q_ff[`WIC_B_BYPASS];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      limit_level_o <= 3'h0;
      attack_time_o <= 2'h0;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_LIMIT) begin
      limit_level_o <= byte_q_ff[`WIC_F_LEVEL];
      attack_time_o <= byte_q_ff[`WIC_F_TIME2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clip_code_o <= 3'h0;
      release_time_o <= 2'h0;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_CLIP) begin
      clip_code_o <= byte_q_ff[`WIC_F_LEVEL];
      release_time_o <= byte_q_ff[`WIC_F_TIME2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      speaker_gain_sel_o <= `WIC_RST_BIT;
      phone_gain_sel_o <= 3'h0;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_GAIN) begin
      speaker_gain_sel_o <= byte_q_ff[`WIC_B_SPK_GAIN];
      phone_gain_sel_o <= byte_q_ff[`WIC_F_PHONE_GAIN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      volume_step_o <= 5'h00;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_VOL) begin
      volume_step_o <= byte_q_ff[`WIC_F_VOL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      gate_level_o <= 2'h0;
      gate_time_o <= 2'h0;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_GATE) begin
      gate_level_o <= byte_q_ff[`WIC_F_GATE_LEVEL];
      gate_time_o <= byte_q_ff[`WIC_F_LOW2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rail_trip_o <= 2'h0;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_RAIL) begin
      rail_trip_o <= byte_q_ff[`WIC_F_LOW2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      spread_enable_o <= `WIC_RST_BIT;
      fast_turn_on_o <= `WIC_RST_BIT;
    end else if (ce_i && wr_ff && tgt == wic_pkg::WIC_T_MISC) begin
      spread_enable_o <= byte_q_ff[`WIC_B_SPREAD];
      fast_turn_on_o <= byte_q_ff[`WIC_B_FAST_ON];
    end
  end

  // ************************************************************
  // Derived controls
  // ************************************************************
  // A disabled device forces every partial shutdown on, whatever its own bit says.
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      device_enable_o <= `WIC_RST_BIT;
      rail_switch_disable_o <= 1'b1;
      right_phone_disable_o <= 1'b1;
      unused_amp_disable_o <= 1'b1;
      class_d_enable_o <= `WIC_RST_BIT;
    end else if (ce_i) begin
      device_enable_o <= en_ff;
      rail_switch_disable_o <= !en_ff || rail_dis_ff;
      right_phone_disable_o <= !en_ff || rphone_dis_ff;
      unused_amp_disable_o <= !en_ff || unused_dis_ff;
      class_d_enable_o <= en_ff && !receiver_bypass_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      limit_active_o <= `WIC_RST_BIT;
      anti_clip_on_o <= `WIC_RST_BIT;
      clip_ctrl_on_o <= `WIC_RST_BIT;
    end else if (ce_i) begin
      limit_active_o <= (limit_level_o >= `WIC_LIM_MIN) && (limit_level_o <= `WIC_LIM_MAX);
      anti_clip_on_o <= (clip_code_o != `WIC_CLIP_OFF);
      clip_ctrl_on_o <= (clip_code_o >= `WIC_CLIP_LOW) && (clip_code_o <= `WIC_CLIP_HIGH);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cs @(posedge clk_i); endclocking
  default disable iff (srst_i || !ce_i);

  shut_write_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_SHUT |=> en_ff == $past(byte_q_ff[0]) && rphone_dis_ff == $past(byte_q_ff[2])) else $error("shutdown byte not stored");
  enable_override_a: assert property (!en_ff |=> rail_switch_disable_o && right_phone_disable_o && unused_amp_disable_o) else $error("disable not forced");
  mode_write_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_MODE |=> mixer_mode_o == $past(byte_q_ff[3:0]) && receiver_bypass_o == $past(byte_q_ff[4])) else $error("mode byte not stored");
  bypass_cut_a: assert property (receiver_bypass_o |=> !class_d_enable_o) else $error("class D on in bypass");
  vol_write_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_VOL |=> volume_step_o == $past(byte_q_ff[4:0])) else $error("volume not stored");
  gain_write_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_GAIN |=> speaker_gain_sel_o == $past(byte_q_ff[3]) && phone_gain_sel_o == $past(byte_q_ff[2:0])) else $error("gain not stored");
  limit_code_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_LIMIT |=> attack_time_o == $past(byte_q_ff[4:3]) ##1 limit_active_o == ($past(byte_q_ff[2:0], 2) inside {[3'h1:3'h6]})) else $error("limiter code wrong");
  clip_code_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_CLIP |=> ##1 anti_clip_on_o == ($past(byte_q_ff[2:0], 2) != 3'h0)) else $error("anti-clip code wrong");
  ext_decode_a: assert property (wr_ff && byte_q_ff[7:2] == 6'h3a |=> rail_trip_o == $past(byte_q_ff[1:0])) else $error("class G byte not stored");
  unlisted_keep_a: assert property (wr_ff && tgt == wic_pkg::WIC_T_NONE |=> $stable(en_ff) && $stable(mixer_mode_o) && $stable(volume_step_o) && $stable(rail_trip_o) && $stable(spread_enable_o)) else $error("unlisted select changed state");
  write_seen_a: assert property (wr_evt |=> wr_ff) else $error("write lost");

  vol_cov_c: cover property (wr_ff && tgt == wic_pkg::WIC_T_VOL);
  bypass_cov_c: cover property (receiver_bypass_o && device_enable_o);
  misc_cov_c: cover property (wr_ff && tgt == wic_pkg::WIC_T_MISC);

endmodule

`default_nettype wire

//--- bench/wic_master_model.sv
/*
  Behavioural two-wire bus master that writes one command byte per frame.
  Assumes a pull-up on SDA, so sda_i reads high whenever nobody pulls it low.
*/
`timescale 1ns/1ps
`default_nettype none

module wic_master_model (
  // Bus pins
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  localparam int HALF = 24;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Data moves only while the clock is low, so it is stable over every high phase.
  task automatic put_bit(input logic b, output logic s);
    sda_o = b;
    #(HALF/2);
    scl_o = 1'b1;
    s = sda_i;
    #HALF;
    scl_o = 1'b0;
    #(HALF/2);
  endtask

  task automatic send_byte(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i], s);
    end
    put_bit(1'b1, s);
    ack = ~s;
  endtask

  // A refused address ends the frame at once, as a real master would.
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic ack_a, output logic ack_d);
    #7;
    sda_o = 1'b0;
    #HALF;
    scl_o = 1'b0;
    #(HALF/2);
    send_byte(a, ack_a);
    ack_d = 1'b0;
    if (ack_a) begin
      send_byte(d, ack_d);
    end
    sda_o = 1'b0;
    #(HALF/2);
    scl_o = 1'b1;
    #HALF;
    sda_o = 1'b1;
  endtask
endmodule

`default_nettype wire

//--- bench/wic_ctrl_top_tb.sv
/*
  Self-checking bench of the control slave: frame table, reset, clock enable.
  Assumes the master model drives the bus and the slave only pulls SDA low.
*/
`timescale 1ns/1ps
`default_nettype none

module wic_ctrl_top_tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b0;
  logic ce_i = 1'b1;
  wire logic scl;
  wire logic sda_m;
  wire logic sda_w;
  wire logic sda_pin;
  wire logic sda_oe;
  wire logic [39:0] q;
  logic [7:0] sh, md, lm, cl, gn, vl, gt, cg, ms;
  logic aa, ad;
  int n_fail = 0;
  int num_checks = 0;
  // Rows: address byte, command byte, expected acknowledge.
  logic [23:0] rows [0:24] = '{24'hc0_11_01, 24'hc0_1e_01, 24'hc0_1f_01, 24'hc0_15_01, 24'hc0_01_01,
    24'hc0_29_01, 24'hc0_3a_01, 24'hc0_4f_01, 24'hc0_5e_01, 24'hc0_41_01, 24'hc0_65_01, 24'hc0_72_01,
    24'hc0_63_01, 24'hc0_8b_01, 24'hc0_a0_01, 24'hc0_bf_01, 24'hc0_cd_01, 24'hc0_eb_01, 24'hc0_f2_01,
    24'hc0_f1_01, 24'hc0_e7_01, 24'hc0_fe_01, 24'hc2_12_00, 24'hc1_10_00, 24'h40_16_00};

  always #50 clk_i = ~clk_i;
  assign sda_w = sda_m & ~sda_oe;

  wic_master_model m (.scl_o(scl), .sda_o(sda_m), .sda_i(sda_w));

  wic_ctrl_top uut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_pin), .sda_oe_o(sda_oe), .device_enable_o(q[39]), .rail_switch_disable_o(q[38]),
    .right_phone_disable_o(q[37]), .unused_amp_disable_o(q[36]), .mixer_mode_o(q[35:32]),
    .receiver_bypass_o(q[31]), .class_d_enable_o(q[30]), .limit_level_o(q[29:27]),
    .limit_active_o(q[26]), .attack_time_o(q[25:24]), .clip_code_o(q[23:21]), .release_time_o(q[20:19]),
    .anti_clip_on_o(q[18]), .clip_ctrl_on_o(q[17]), .speaker_gain_sel_o(q[16]),
    .phone_gain_sel_o(q[15:13]), .volume_step_o(q[12:8]), .gate_level_o(q[7:6]), .gate_time_o(q[5:4]),
    .rail_trip_o(q[3:2]), .spread_enable_o(q[1]), .fast_turn_on_o(q[0]));

  task automatic clr_model();
    {sh, md, lm, cl, gn, vl, gt, cg, ms} = '0;
  endtask

  task automatic apply(input logic [7:0] b);
    case (b[7:5])
      3'h0: if (b[4]) sh = b;
      3'h1: md = b;
      3'h2: lm = b;
      3'h3: cl = b;
      3'h4: gn = b;
      3'h5: vl = b;
      3'h6: gt = b;
      default: begin
        if (b[4:2] == 3'h2) cg = b;
        else if (b[4:2] == 3'h4) ms = b;
      end
    endcase
  endtask

  // The enable bit being clear forces every disable output high.
  function automatic logic [39:0] exp_q();
    logic en;
    en = sh[0];
    return {en, ~en | sh[1], ~en | sh[2], ~en | sh[3], md[3:0], md[4], en & ~md[4], lm[2:0],
      (lm[2:0] != 3'h0 && lm[2:0] != 3'h7), lm[4:3], cl[2:0], cl[4:3], cl[2:0] != 3'h0,
      (cl[2:0] >= 3'h3 && cl[2:0] <= 3'h5), gn[3], gn[2:0], vl[4:0], gt[3:2], gt[1:0], cg[1:0], ms[1], ms[0]};
  endfunction

  task automatic chk_ack(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: bus bit %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic chk_q(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: controls %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    n_fail++;
    stop_test();
  end

  initial begin
    clr_model();
    // The link side clears on the rising edge of reset, so reset must rise as an event, not as an initial value.
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    chk_q(q, exp_q());
    chk_ack(sda_oe, 1'b0);
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 25; i++) begin
      m.frame(rows[i][23:16], rows[i][15:8], aa, ad);
      chk_ack(aa, rows[i][0]);
      chk_ack(ad, rows[i][0]);
      if (rows[i][0]) apply(rows[i][15:8]);
      repeat (10) @(posedge clk_i);
      chk_q(q, exp_q());
    end
    chk_ack(sda_pin, 1'b0);
    // A byte taken while the enable is low waits in the link side until it rises.
    ce_i <= 1'b0;
    m.frame(8'hc0, 8'hb5, aa, ad);
    repeat (10) @(posedge clk_i);
    chk_q(q, exp_q());
    ce_i <= 1'b1;
    apply(8'hb5);
    repeat (10) @(posedge clk_i);
    chk_q(q, exp_q());
    srst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    clr_model();
    chk_q(q, exp_q());
    srst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    m.frame(8'hc0, 8'h19, aa, ad);
    chk_ack(ad, 1'b1);
    apply(8'h19);
    repeat (10) @(posedge clk_i);
    chk_q(q, exp_q());
    stop_test();
  end
endmodule

`default_nettype wire
